// ==== rtl/msr_map.svh ====
// Purpose: register offsets, field positions, reset values and timing
// Assumes: included by bare name wherever the map is needed
// Notes: byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH
`define MSR_OFS_SAMP 8'h00
`define MSR_OFS_RPT 8'h04
`define MSR_OFS_RANGE 8'h08
`define MSR_OFS_STAT 8'h0c
`define MSR_OFS_MODE 8'h10
`define MSR_OFS_DROP 8'h14
`define MSR_ACC_POS 0
`define MSR_MAG_POS 8
`define MSR_MODE_POS 16
`define MSR_SLEEP_POS 18
`define MSR_SAMP_RST 16'h0064
`define MSR_RPT_RST 16'h0064
`define MSR_SAMP_MIN 16'h000a
`define MSR_RPT_MIN 16'h0001
`define MSR_ACC_DISCARD 2'h2
`define MSR_MODE_MAX 8'h02
`define MSR_BY_GNS 0
`define MSR_BY_TGT 1
`define MSR_BY_VAL 5
`define MSR_CODE_A 8'h01
`define MSR_CODE_B 8'h00
`define MSR_CODE_C 8'h00
`define MSR_GNS_SET 8'h00
`define MSR_GNS_GET 8'h01
`define MSR_TGT_RAM 8'h00
`define MSR_TGT_FLASH 8'h01
`define MSR_CLK_NS 4
`define MSR_MS_NS 1000000
`define MSR_SLEEP_MS 3000
`define MSR_FRAC 10
`endif

// ==== rtl/msr_pkg.sv ====
// Purpose: types shared by the report engine files
// Assumes: constants live in msr_map.svh
// Notes: report fields are packed most significant first
`default_nettype none
package msr_pkg;
    typedef enum logic [1:0] {
        MSR_RUN = 2'b01,
        MSR_SLEEP = 2'b10
    } msr_pwr_t;
    typedef logic [15:0] msr_word_t;
    typedef struct packed {
        msr_word_t x;
        msr_word_t y;
        msr_word_t z;
    } msr_vec_t;
    typedef struct packed {
        msr_vec_t acc;
        msr_vec_t mag;
    } msr_sample_t;
    typedef struct packed {
        msr_word_t frame;
        msr_sample_t meas;
    } msr_report_t;
    typedef logic [31:0][7:0] msr_feat_t;
    typedef struct packed {
        logic act;
        logic wr;
        logic hit;
        logic [7:0] addr;
    } msr_ahb_ap_t;
    typedef struct packed {
        msr_pwr_t pwr;
        logic attach;
        msr_ahb_ap_t ap;
        logic [31:0] hrdata;
        logic [15:0] samp_ms;
        logic [15:0] rpt_ms;
        logic [1:0] acc_rng;
        logic [7:0] mag_mode;
        logic [1:0] mode_ram;
        logic [1:0] mode_flash;
        logic [31:0] ms_cnt;
        logic [15:0] frame;
        logic [15:0] samp_cnt;
        logic [15:0] rpt_cnt;
        logic [15:0] idle_cnt;
        logic [15:0] drops;
        logic smp_req;
        msr_sample_t last;
        logic have_smp;
        msr_sample_t last_sent;
        logic sent_any;
        logic rpt_valid;
        msr_report_t rpt;
        logic rsp_valid;
        msr_feat_t rsp;
    } msr_state_t;
endpackage : msr_pkg
`default_nettype wire

// ==== rtl/msr_scale.sv ====
// Purpose: scale raw sensor counts into report units
// Assumes: acceleration counts are 1, 2 or 4 mg depending on range
// Notes: purely combinational, results saturate to 16 bits
`default_nettype none
`include "msr_map.svh"
module msr_scale #(
    parameter int ACC_NUM = 10042,
    parameter int MAG_NUM = 1024
) (
    // range settings
    input wire logic [1:0] acc_rng,
    input wire logic [7:0] mag_mode,
    // samples
    input wire msr_pkg::msr_sample_t raw,
    output var msr_pkg::msr_sample_t scaled
);
    logic [2:0][15:0] acc_in;
    logic [2:0][15:0] mag_in;
    logic [2:0][15:0] acc_out;
    logic [2:0][15:0] mag_out;
    logic [4:0] shl;

    function automatic logic [15:0] msr_sat(input logic signed [47:0] v);
        if (v > 48'sh7fff) begin
            return 16'h7fff;
        end
        if (v < -48'sh8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : msr_sat

    assign acc_in = raw.acc;
    assign mag_in = raw.mag;

    // count weight doubles with each wider range
    always_comb begin
        case (acc_rng)
            2'h1: shl = 5'h01;
            2'h3: shl = 5'h02;
            default: shl = 5'h00;
        endcase
    end

    for (genvar i = 0; i < 3; i++) begin : g_axis
        // mg times 9.8066 gives thousandths of m/s2
        assign acc_out[i] = msr_sat(((48'(signed'(acc_in[i])) <<< shl) * 48'(ACC_NUM))
            >>> `MSR_FRAC);
        // gain only holds in the default range, otherwise raw counts pass
        assign mag_out[i] = (mag_mode == 8'h00)
            ? msr_sat((48'(signed'(mag_in[i])) * 48'(MAG_NUM)) >>> `MSR_FRAC)
            : mag_in[i];
    end

    assign scaled.acc = acc_out;
    assign scaled.mag = mag_out;
endmodule : msr_scale
`default_nettype wire

// ==== rtl/msr_engine.sv ====
// Purpose: sample timing, report formation and feature command decode
// Assumes: one clock, synchronous reset, AHB-Lite register access
// Notes: the usb stack outside carries reports and feature packets
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`default_nettype none
`include "msr_map.svh"
// Summary of operation
// - readings leave as interrupt-in reports, apart from the feature channel
// - each report starts with a 16-bit millisecond frame number
// - then acceleration x, y, z in thousandths of m/s2
// - then magnetic field x, y, z in ten-thousandths of a gauss
// - magnetic scaling only in default range, else raw counts for the host
// - feature commands and answers are fixed 32-byte packets
// - report-mode command: selector, target, code 01 00 00, mode in byte 5
// - target 0 picks working memory, 1 picks persistent storage
// - mode 0 after every sample, 1 after change, 2 fixed rate
// - sample interval adjustable from 10 ms to 65 s
// - report interval adjustable from 1 ms to 65 s
// - acceleration range 2, 4 or 8 g, default 2 g
// - seven magnetic ranges, 1.3 G to 8.1 G, default 2.5 G
// - device attaches as a full-speed usb hid
// - device enters sleep by itself, no host command needed
// - report interval counts only in fixed-rate mode
// - mode 0 sends at most one report per sample
module msr_engine #(
    parameter int MS_CYCLES = `MSR_MS_NS / `MSR_CLK_NS,
    parameter int SLEEP_MS = `MSR_SLEEP_MS,
    parameter int ACC_NUM = 10042,
    parameter int MAG_NUM = 1024
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // sensor
    output logic smp_req,
    input wire logic smp_valid,
    input wire msr_pkg::msr_sample_t smp_raw,
    // interrupt-in reports
    output logic rpt_valid,
    input wire logic rpt_ready,
    output msr_pkg::msr_report_t rpt_data,
    // feature reports
    input wire logic feat_valid,
    input wire msr_pkg::msr_feat_t feat_cmd,
    output logic feat_rsp_valid,
    output msr_pkg::msr_feat_t feat_rsp,
    // usb and power
    input wire logic usb_active,
    output logic dp_pullup,
    output logic sleep
);
    msr_pkg::msr_state_t st;
    msr_pkg::msr_state_t next_st;
    msr_pkg::msr_sample_t scaled;
    msr_pkg::msr_sample_t snd_val;
    logic ms_tick;
    logic wake;
    logic running;
    logic slot_free;
    logic snd_smp;
    logic snd_fix;
    logic is_mode_cmd;
    logic [1:0] mode;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction : clamp_min

    function automatic logic [31:0] reg_word(input msr_pkg::msr_state_t s,
                                             input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            `MSR_OFS_SAMP: begin
                w[15:0] = s.samp_ms;
            end
            `MSR_OFS_RPT: begin
                w[15:0] = s.rpt_ms;
            end
            `MSR_OFS_RANGE: begin
                w[`MSR_ACC_POS +: 2] = s.acc_rng;
                w[`MSR_MAG_POS +: 8] = s.mag_mode;
            end
            `MSR_OFS_STAT: begin
                w[15:0] = s.frame;
                w[`MSR_MODE_POS +: 2] = s.mode_ram;
                w[`MSR_SLEEP_POS] = (s.pwr == msr_pkg::MSR_SLEEP);
            end
            `MSR_OFS_MODE: begin
                w[1:0] = s.mode_ram;
            end
            `MSR_OFS_DROP: begin
                w[15:0] = s.drops;
            end
            default: begin
                w = 32'h0;
            end
        endcase
        return w;
    endfunction : reg_word

    msr_scale #(
        .ACC_NUM(ACC_NUM),
        .MAG_NUM(MAG_NUM)
    ) u_scale (
        .acc_rng(st.acc_rng),
        .mag_mode(st.mag_mode),
        .raw(smp_raw),
        .scaled(scaled)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.smp_req = 1'b0;
        next_st.rsp_valid = 1'b0;
        next_st.attach = 1'b1;
        mode = st.mode_ram;
        running = (st.pwr == msr_pkg::MSR_RUN);
        wake = usb_active | feat_valid;

        // millisecond base and frame number
        ms_tick = (st.ms_cnt == 32'(MS_CYCLES - 1));
        next_st.ms_cnt = ms_tick ? 32'h0 : st.ms_cnt + 32'h1;
        if (ms_tick) begin
            next_st.frame = st.frame + 16'h1;
        end

        // idle time and automatic sleep
        if (wake) begin
            next_st.idle_cnt = 16'h0;
        end else if (ms_tick && st.idle_cnt != 16'(SLEEP_MS)) begin
            next_st.idle_cnt = st.idle_cnt + 16'h1;
        end
        case (st.pwr)
            msr_pkg::MSR_RUN: begin
                if (!wake && st.idle_cnt == 16'(SLEEP_MS)) begin
                    next_st.pwr = msr_pkg::MSR_SLEEP;
                end
            end
            msr_pkg::MSR_SLEEP: begin
                if (wake) begin
                    next_st.pwr = msr_pkg::MSR_RUN;
                end
            end
            default: begin
                next_st.pwr = msr_pkg::MSR_RUN;
            end
        endcase

        // sample timer, halted while asleep to save power
        if (ms_tick && running) begin
            if (st.samp_cnt >= st.samp_ms - 16'h1) begin
                next_st.samp_cnt = 16'h0;
                next_st.smp_req = 1'b1;
            end else begin
                next_st.samp_cnt = st.samp_cnt + 16'h1;
            end
        end
        if (smp_valid) begin
            next_st.last = scaled;
            next_st.have_smp = 1'b1;
        end

        // report timing modes
        snd_smp = 1'b0;
        snd_fix = 1'b0;
        case (mode)
            2'h0: begin
                snd_smp = smp_valid;
            end
            2'h1: begin
                snd_smp = smp_valid && (!st.sent_any || scaled != st.last_sent);
            end
            default: begin
                snd_smp = 1'b0;
            end
        endcase
        if (mode == 2'h2) begin
            if (ms_tick) begin
                if (st.rpt_cnt >= st.rpt_ms - 16'h1) begin
                    next_st.rpt_cnt = 16'h0;
                    snd_fix = st.have_smp;
                end else begin
                    next_st.rpt_cnt = st.rpt_cnt + 16'h1;
                end
            end
        end else begin
            next_st.rpt_cnt = 16'h0;
        end

        // one report slot; a report that finds it full is dropped and counted
        snd_val = snd_smp ? scaled : st.last;
        slot_free = !st.rpt_valid || rpt_ready;
        if (st.rpt_valid && rpt_ready) begin
            next_st.rpt_valid = 1'b0;
        end
        if (snd_smp || snd_fix) begin
            if (slot_free) begin
                next_st.rpt_valid = 1'b1;
                next_st.rpt.frame = st.frame;
                next_st.rpt.meas = snd_val;
                next_st.last_sent = snd_val;
                next_st.sent_any = 1'b1;
            end else begin
                next_st.drops = st.drops + 16'h1;
            end
        end

        // feature command decode, answer echoes the packet except a get, which puts the mode in byte 5
        is_mode_cmd = (feat_cmd[2] == `MSR_CODE_A) && (feat_cmd[3] == `MSR_CODE_B)
            && (feat_cmd[4] == `MSR_CODE_C);
        if (feat_valid) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp = feat_cmd;
            if (is_mode_cmd) begin
                if (feat_cmd[`MSR_BY_GNS] == `MSR_GNS_SET
                    && feat_cmd[`MSR_BY_VAL] <= `MSR_MODE_MAX) begin
                    if (feat_cmd[`MSR_BY_TGT] == `MSR_TGT_RAM) begin
                        next_st.mode_ram = feat_cmd[`MSR_BY_VAL][1:0];
                    end else if (feat_cmd[`MSR_BY_TGT] == `MSR_TGT_FLASH) begin
                        next_st.mode_flash = feat_cmd[`MSR_BY_VAL][1:0];
                    end
                end else if (feat_cmd[`MSR_BY_GNS] == `MSR_GNS_GET) begin
                    if (feat_cmd[`MSR_BY_TGT] == `MSR_TGT_FLASH) begin
                        next_st.rsp[`MSR_BY_VAL] = {6'h0, st.mode_flash};
                    end else begin
                        next_st.rsp[`MSR_BY_VAL] = {6'h0, st.mode_ram};
                    end
                end
            end
        end

        // ahb data phase: writes land before the next read is sampled
        if (st.ap.act && st.ap.wr && st.ap.hit) begin
            case (st.ap.addr)
                `MSR_OFS_SAMP: begin
                    next_st.samp_ms = clamp_min(hwdata[15:0], `MSR_SAMP_MIN);
                end
                `MSR_OFS_RPT: begin
                    next_st.rpt_ms = clamp_min(hwdata[15:0], `MSR_RPT_MIN);
                end
                `MSR_OFS_RANGE: begin
                    if (hwdata[`MSR_ACC_POS +: 2] != `MSR_ACC_DISCARD) begin
                        next_st.acc_rng = hwdata[`MSR_ACC_POS +: 2];
                    end
                    next_st.mag_mode = hwdata[`MSR_MAG_POS +: 8];
                end
                `MSR_OFS_MODE: begin
                    if (hwdata[7:0] <= `MSR_MODE_MAX) begin
                        next_st.mode_ram = hwdata[1:0];
                    end
                end
                default: begin
                    next_st.ap.act = st.ap.act;
                end
            endcase
        end

        // ahb address phase
        next_st.ap.act = hsel && htrans[1] && hready;
        next_st.ap.wr = hwrite;
        next_st.ap.hit = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);
        next_st.ap.addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            next_st.hrdata = next_st.ap.hit ? reg_word(next_st, haddr[7:0]) : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
            st.pwr <= msr_pkg::MSR_RUN;
            st.samp_ms <= `MSR_SAMP_RST;
            st.rpt_ms <= `MSR_RPT_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // wait states only while frozen, so a held bus never loses a beat
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign smp_req = st.smp_req;
    assign rpt_valid = st.rpt_valid;
    assign rpt_data = st.rpt;
    assign feat_rsp_valid = st.rsp_valid;
    assign feat_rsp = st.rsp;
    assign dp_pullup = st.attach;
    assign sleep = (st.pwr == msr_pkg::MSR_SLEEP);
endmodule : msr_engine
`default_nettype wire

// ==== test/msr_host.sv ====
// Purpose: host side model that takes interrupt-in reports
// Assumes: one clock, the bench drives stall to hold reports back
// Notes: keeps the last two reports taken so the bench can compare them
`default_nettype none
module msr_host (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // interrupt-in channel
    input wire logic rpt_valid,
    output var logic rpt_ready,
    input wire msr_pkg::msr_report_t rpt_data,
    // bench control and view
    input wire logic stall,
    output var int n_taken,
    output var msr_pkg::msr_report_t last,
    output var msr_pkg::msr_report_t prev
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // report intake
    // ----------------------------------------
    always @(posedge clock) begin
        rpt_ready <= !stall && !reset;
        if (reset) begin
            n_taken <= 0;
        end else if (rpt_valid && rpt_ready) begin
            n_taken <= n_taken + 1;
            prev <= last;
            last <= rpt_data;
        end
    end
endmodule : msr_host
`default_nettype wire

// ==== test/msr_chk.sv ====
// Purpose: port checker for the report engine
// Assumes: bound to msr_engine, single clock domain
// Notes: ce is tied high by the bench, so no frozen cycles are modelled
`default_nettype none
module msr_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    // watched ports
    input wire logic smp_req,
    input wire logic sleep,
    input wire logic dp_pullup,
    input wire logic rpt_valid,
    input wire logic rpt_ready,
    input wire msr_pkg::msr_report_t rpt_data,
    input wire logic feat_valid,
    input wire msr_pkg::msr_feat_t feat_cmd,
    input wire logic feat_rsp_valid,
    input wire msr_pkg::msr_feat_t feat_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    attach_in_reset_a: assert property (disable iff (1'b0) reset |=> !dp_pullup)
        else $error("pullup high during reset");
    feat_answer_a: assert property (feat_valid && ce |=> feat_rsp_valid)
        else $error("feature command not answered");
    feat_single_a: assert property (feat_rsp_valid && !feat_valid |=> !feat_rsp_valid)
        else $error("feature answer longer than one cycle");
    feat_code_echo_a: assert property (feat_rsp_valid |-> feat_rsp[4:2] == $past(feat_cmd[4:2]))
        else $error("command code bytes not echoed");
    feat_target_a: assert property (feat_rsp_valid |-> feat_rsp[1:0] == $past(feat_cmd[1:0]))
        else $error("selector or target not echoed");
    set_value_echo_a: assert property (feat_valid && feat_cmd[0] == 8'h00
        |=> feat_rsp[5] == $past(feat_cmd[5]))
        else $error("set value not echoed");
    report_hold_a: assert property (rpt_valid && !rpt_ready && ce
        |=> rpt_valid && $stable(rpt_data))
        else $error("report dropped or changed before taken");
    sample_pulse_a: assert property (smp_req |=> !smp_req)
        else $error("sample request longer than one cycle");
    sleep_quiet_a: assert property (sleep && $past(sleep) |-> !smp_req)
        else $error("sampling while asleep");
endmodule : msr_chk
bind msr_engine msr_chk u_chk (.clock(clock), .reset(reset), .ce(ce), .smp_req(smp_req),
    .sleep(sleep), .dp_pullup(dp_pullup), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
    .rpt_data(rpt_data), .feat_valid(feat_valid), .feat_cmd(feat_cmd),
    .feat_rsp_valid(feat_rsp_valid), .feat_rsp(feat_rsp));
`default_nettype wire

// ==== test/motion_sensor_report_engine_bench.sv ====
// Purpose: self-checking bench for the report engine
// Assumes: millisecond shortened to MS cycles, sleep after 5 ms
// Notes: register rows first, then report modes, feature commands, sleep
`default_nettype none
module motion_sensor_report_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic clock, reset, ce, hsel, hwrite, smp_valid, feat_valid, usb_active, stall;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, smp_req, rpt_valid, rpt_ready, feat_rsp_valid, dp_pullup, sleep;
    msr_pkg::msr_sample_t smp_raw, s_a, s_b;
    msr_pkg::msr_report_t rpt_data, last, prev;
    msr_pkg::msr_feat_t feat_cmd, feat_rsp;
    int n_errors, comparisons, n_taken, c;
    // rows: addr, write flag, write data, expected read
    logic [47:0] regs [15] = '{48'h000000000064, 48'h040000000064, 48'h080000000000,
        48'h100000000000, 48'h140000000000, 48'h00010005000a, 48'h0001000c000c,
        48'h040100000001, 48'h080100020000, 48'h080100010001, 48'h080100030003,
        48'h080100000000, 48'h100100030000, 48'h140100050000, 48'h400100070000};
    // rows: selector, target, value, expected byte 5
    logic [31:0] feats [7] = '{32'h00000101, 32'h01000001, 32'h00010202, 32'h01010002,
        32'h01000001, 32'h00000303, 32'h01000001};

    msr_engine #(.MS_CYCLES(MS), .SLEEP_MS(5)) dut (.clock(clock), .reset(reset), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .smp_req(smp_req), .smp_valid(smp_valid), .smp_raw(smp_raw),
        .rpt_valid(rpt_valid), .rpt_ready(rpt_ready), .rpt_data(rpt_data),
        .feat_valid(feat_valid), .feat_cmd(feat_cmd), .feat_rsp_valid(feat_rsp_valid),
        .feat_rsp(feat_rsp), .usb_active(usb_active), .dp_pullup(dp_pullup), .sleep(sleep));
    msr_host host (.clock(clock), .reset(reset), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
        .rpt_data(rpt_data), .stall(stall), .n_taken(n_taken), .last(last), .prev(prev));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task final_report;
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // called just after a rising edge; no fixed latency assumed
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic sample(input msr_pkg::msr_sample_t s);
        smp_valid <= 1'b1;
        smp_raw <= s;
        @(posedge clock);
        smp_valid <= 1'b0;
        smp_raw <= ~s;
        repeat (3) @(posedge clock);
    endtask : sample
    task automatic feat(input logic [31:0] row);
        msr_pkg::msr_feat_t cmd;
        cmd = '0;
        cmd[0] = row[31:24];
        cmd[1] = row[23:16];
        cmd[2] = 8'h01;
        cmd[5] = row[15:8];
        feat_valid <= 1'b1;
        feat_cmd <= cmd;
        @(posedge clock);
        feat_valid <= 1'b0;
        @(posedge clock);
        check("feature answer", feat_rsp_valid, 32'h1);
        check("feature mode byte", feat_rsp[5], row[7:0]);
    endtask : feat

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        final_report();
    end
    initial begin
        {reset, ce, hsel, hwrite, smp_valid, feat_valid, usb_active, stall} = 8'hc2;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        smp_raw = '0;
        feat_cmd = '0;
        s_a = {16'h0400, 16'h0000, 16'h0200, 16'h0100, 16'h0200, 16'h0300};
        s_b = s_a;
        s_b.mag.z = 16'h0301;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        check("pullup", dp_pullup, 32'h1);
        foreach (regs[i]) begin
            if (regs[i][32]) ahb(1'b1, 32'(regs[i][47:40]), 32'(regs[i][31:16]));
            ahb(1'b0, 32'(regs[i][47:40]), 32'h0);
            check("register", rd, 32'(regs[i][15:0]));
            check("response", 32'(hresp), 32'h0);
        end
        // last row pair leaves the sample interval at 12 ms
        do @(posedge clock); while (smp_req !== 1'b1);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (smp_req !== 1'b1);
        check("sample period", c, 32'(12 * MS));
        c = n_taken;
        sample(s_a);
        sample(s_a);
        check("mode 0 count", n_taken - c, 32'h2);
        check("acc x", last.meas.acc.x, 32'h273a);
        check("acc z", last.meas.acc.z, 32'h139d);
        check("mag x", last.meas.mag.x, 32'h0100);
        check("mag y", last.meas.mag.y, 32'h0200);
        check("mag z", last.meas.mag.z, 32'h0300);
        ahb(1'b1, 32'h08, 32'h0101);
        sample(s_a);
        check("acc x 4g", last.meas.acc.x, 32'h4e74);
        check("mag raw", last.meas.mag.z, 32'h0300);
        ahb(1'b1, 32'h08, 32'h0);
        ahb(1'b1, 32'h10, 32'h1);
        sample(s_a);
        c = n_taken;
        sample(s_a);
        check("mode 1 same", n_taken - c, 32'h0);
        sample(s_b);
        repeat (4 * MS) @(posedge clock);
        check("mode 1 change", n_taken - c, 32'h1);
        ahb(1'b1, 32'h04, 32'h2);
        ahb(1'b1, 32'h10, 32'h2);
        repeat (7 * MS) @(posedge clock);
        check("rate frames", last.frame - prev.frame, 32'h2);
        check("rate data", last.meas.mag.z, 32'h0301);
        foreach (feats[i]) feat(feats[i]);
        ahb(1'b0, 32'h10, 32'h0);
        check("working mode", rd, 32'h1);
        usb_active <= 1'b0;
        repeat (8 * MS) @(posedge clock);
        check("asleep", sleep, 32'h1);
        usb_active <= 1'b1;
        repeat (3) @(posedge clock);
        check("awake", sleep, 32'h0);
        // host holds back: first report waits in the slot, second is dropped
        c = n_taken;
        stall <= 1'b1;
        sample(s_a);
        sample(s_b);
        check("held", n_taken - c, 32'h0);
        ahb(1'b0, 32'h14, 32'h0);
        check("dropped", rd, 32'h1);
        stall <= 1'b0;
        repeat (3) @(posedge clock);
        check("released", n_taken - c, 32'h1);
        check("released data", last.meas.mag.z, 32'h0300);
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        ahb(1'b0, 32'h10, 32'h0);
        check("default mode", rd, 32'h0);
        final_report();
    end
endmodule : motion_sensor_report_engine_bench
`default_nettype wire
